// >>> verilog/priority_interrupt_controller.sv
// Purpose: 40-source, 32-level interrupt controller with APB registers
// Assumes: Sources are levels held until cleared at the source
// Notes: Requests to the CPU are active low and registered once
// Function
// RQ1: 40 sources, each 5-bit level select
// RQ2: Level 31 highest; sources reset to 0
// RQ3: Force bits ORed with sources
// RQ4: Level pending shows active levels
// RQ5: Fast pending is mask AND levels
// RQ6: Normal pending is mask AND levels
// RQ7: Encoders give highest set level
// RQ8: Normal request only while fast negated
// RQ9: Fast wins; vector from fast
// RQ10: Both classes pend when both enabled
// RQ11: No edge detect; pending read-only
// RQ12: Threshold blocks levels at/below value
// RQ13: Class bit picks which requests mask
// RQ14: Status shows vector and requests
// RQ15: Outputs registered, one clock latency
// RQ16: Raw combinational requests for wakeup; code sends them through one flop, like the CPU requests
// RQ17: Autovector resets set; no vector
// RQ18: Vector low bits are highest level
// RQ19: Vector 6:5 is 10 fast-separate else 01
// RQ20: Levels map to 32-63 or 64-95
// RQ21: Reset clears masks and levels
// RQ22: Software configures CPU, controller, sources
// RQ23: Pending writes ignored, complete normally
// RQ24: Force high 39:32, low 31:0
// RQ25: Level pending from matching unmasked sources

`timescale 1ns/1ps

module priority_interrupt_controller (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [39:0] source_req_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic fast_req_n_o,
	output logic normal_req_n_o,
	output logic [6:0] vector_o,
	output logic autovector_o,
	output logic fast_raw_n_o,
	output logic normal_raw_n_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		intc_pkg::control_s ctl;
		logic [39:0] force_request_bits;
		logic [31:0] fast_enable_mask;
		logic [31:0] normal_enable_mask;
		logic [39:0][4:0] source_priority;
		intc_pkg::cpu_req_s cpu;
		logic autovec;
		logic fast_raw_n;
		logic normal_raw_n;
		logic [31:0] rdata;
		logic ready;
	} state_s;

	state_s state_reg; // All flops except the reset release pipe
	state_s state_next; // Next value
	logic [1:0] rst_sync_reg; // Reset release pipe
	logic rst_n; // Released reset

	// Combinational request path, shared by raw and registered outputs
	logic [39:0] merged_req; // Sources with forced bits
	logic [31:0] level_pending_reg; // Unmasked active levels
	logic [31:0] fast_pending_reg; // Fast class pending
	logic [31:0] normal_pending_reg; // Normal class pending
	logic [31:0] below_mask; // Levels at or below threshold
	logic [4:0] fast_top; // Highest fast level
	logic [4:0] normal_top; // Highest normal level
	logic fast_any; // Any fast pending
	logic normal_any; // Any normal pending
	logic access; // APB access phase
	logic [5:0] prio_idx; // Priority word index
	logic prio_hit; // Address in priority block
	logic [11:0] prio_ofs; // Offset within block

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Async assert, synchronous release avoids recovery hazards
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// Highest-set-bit encoder
	// ----------------------------------------
	// Scan upward so the last hit is the highest level
	function automatic logic [4:0] top_level(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Level merge and masking
	// ----------------------------------------
	// Pure levels: no edge capture anywhere on this path
	always_comb begin
		merged_req = source_req_i | state_reg.force_request_bits; // RQ3 RQ11
		level_pending_reg = intc_pkg::ZERO_WORD;
		for (int s = 0; s < intc_pkg::NUM_SOURCES; s++) begin
			if (merged_req[s]) begin
				// Each source lands on its selected level
				level_pending_reg[state_reg.source_priority[s]] = 1'b1; // RQ4 RQ25
			end
		end
		// Threshold covers levels 0 up to the field value
		for (int l = 0; l < intc_pkg::NUM_LEVELS; l++) begin
			below_mask[l] = state_reg.ctl.threshold_enable &&
				(5'(l) <= state_reg.ctl.threshold); // RQ12
		end
		// Class bit clear: only normal masked; set: both masked
		fast_pending_reg = state_reg.fast_enable_mask & level_pending_reg
			& ~(state_reg.ctl.mask_class_select ? below_mask
			: intc_pkg::ZERO_WORD); // RQ5 RQ10 RQ13
		normal_pending_reg = state_reg.normal_enable_mask
			& level_pending_reg & ~below_mask; // RQ6 RQ10 RQ13
		fast_any = |fast_pending_reg;
		normal_any = |normal_pending_reg;
		fast_top = top_level(fast_pending_reg); // RQ7
		normal_top = top_level(normal_pending_reg); // RQ7
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		access = psel_i && penable_i;
		prio_ofs = paddr_i - intc_pkg::PRIO_BASE_OFS;
		prio_idx = prio_ofs[7:2];
		prio_hit = (paddr_i >= intc_pkg::PRIO_BASE_OFS) &&
			(prio_idx < 6'(intc_pkg::NUM_SOURCES)) &&
			(paddr_i[1:0] == 2'b00) && (prio_ofs[11:8] == 4'h0);

		// Raw requests feed stop-mode wakeup, one flop for a clean pin
		state_next.fast_raw_n = ~fast_any; // RQ16 RQ5
		state_next.normal_raw_n = ~(normal_any && !fast_any); // RQ16 RQ8

		// Registered CPU requests: one clock behind pending state
		state_next.cpu.fast_n = ~fast_any; // RQ15 RQ5
		state_next.cpu.normal_n = ~(normal_any && !fast_any); // RQ15 RQ8
		state_next.autovec = state_reg.ctl.autovector_select; // RQ17
		if (state_reg.ctl.autovector_select) begin
			// No vector number when autovectored
			state_next.cpu.vector = 7'h00; // RQ17
		end else if (fast_any) begin
			// Fast wins even if normal level is higher
			state_next.cpu.vector = {
				state_reg.ctl.separate_fast_vectors ?
				intc_pkg::VEC_HI_FAST : intc_pkg::VEC_HI_NORMAL,
				fast_top}; // RQ9 RQ18 RQ19 RQ20
		end else begin
			state_next.cpu.vector = {intc_pkg::VEC_HI_NORMAL,
				normal_top}; // RQ18 RQ19 RQ20
		end

		// APB: zero-wait answer, ready pulses in access phase
		state_next.ready = psel_i && !penable_i;
		state_next.rdata = intc_pkg::ZERO_WORD;
		if (psel_i && !penable_i && !pwrite_i) begin
			// Read data captured in setup, stands through access
			unique case (paddr_i)
				intc_pkg::CONTROL_OFS: begin
					state_next.rdata = 32'({state_reg.ctl.autovector_select,
						state_reg.ctl.separate_fast_vectors,
						state_reg.ctl.mask_class_select,
						state_reg.ctl.threshold_enable,
						state_reg.ctl.threshold});
				end
				intc_pkg::STATUS_OFS: begin
					// Requests at 9 and 8, autovector flag at 7
					state_next.rdata = 32'({state_reg.cpu.fast_n,
						state_reg.cpu.normal_n, state_reg.autovec,
						state_reg.cpu.vector}); // RQ14
				end
				intc_pkg::FORCE_HIGH_OFS: begin
					state_next.rdata = 32'(state_reg.force_request_bits[39:32]);
				end
				intc_pkg::FORCE_LOW_OFS: begin
					state_next.rdata = state_reg.force_request_bits[31:0];
				end
				intc_pkg::LEVEL_PEND_OFS: begin
					state_next.rdata = level_pending_reg; // RQ4
				end
				intc_pkg::NORMAL_EN_OFS: begin
					state_next.rdata = state_reg.normal_enable_mask;
				end
				intc_pkg::NORMAL_PEND_OFS: begin
					state_next.rdata = normal_pending_reg; // RQ6
				end
				intc_pkg::FAST_EN_OFS: begin
					state_next.rdata = state_reg.fast_enable_mask;
				end
				intc_pkg::FAST_PEND_OFS: begin
					state_next.rdata = fast_pending_reg; // RQ5
				end
				default: begin
					if (prio_hit) begin
						state_next.rdata =
							32'(state_reg.source_priority[prio_idx]);
					end
				end
			endcase
		end

		// Writes take effect at the completing edge only
		if (access && pwrite_i && state_reg.ready) begin
			unique case (paddr_i)
				intc_pkg::CONTROL_OFS: begin
					state_next.ctl.threshold = pwdata_i[4:0]; // RQ12
					state_next.ctl.threshold_enable =
						pwdata_i[intc_pkg::CTL_ENABLE_BIT];
					state_next.ctl.mask_class_select =
						pwdata_i[intc_pkg::CTL_CLASS_BIT]; // RQ13
					state_next.ctl.separate_fast_vectors =
						pwdata_i[intc_pkg::CTL_SEPFAST_BIT]; // RQ19
					state_next.ctl.autovector_select =
						pwdata_i[intc_pkg::CTL_AUTOVEC_BIT]; // RQ17
				end
				intc_pkg::FORCE_HIGH_OFS: begin
					state_next.force_request_bits[39:32] =
						pwdata_i[7:0]; // RQ24
				end
				intc_pkg::FORCE_LOW_OFS: begin
					state_next.force_request_bits[31:0] = pwdata_i; // RQ24
				end
				intc_pkg::NORMAL_EN_OFS: begin
					state_next.normal_enable_mask = pwdata_i;
				end
				intc_pkg::FAST_EN_OFS: begin
					state_next.fast_enable_mask = pwdata_i;
				end
				default: begin
					// Pending and status words ignore writes
					if (prio_hit) begin
						state_next.source_priority[prio_idx] =
							pwdata_i[4:0]; // RQ1 RQ2
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Clock enable low freezes everything but the reset release pipe, bus included
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0; // RQ21 RQ2
			state_reg.ctl.autovector_select <= intc_pkg::AUTOVEC_RESET;
			state_reg.autovec <= intc_pkg::AUTOVEC_RESET;
			state_reg.cpu.fast_n <= 1'b1;
			state_reg.cpu.normal_n <= 1'b1;
			state_reg.fast_raw_n <= 1'b1;
			state_reg.normal_raw_n <= 1'b1;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs, straight from flops; error tied low
	// ----------------------------------------
	assign prdata_o = state_reg.rdata;
	assign pready_o = state_reg.ready;
	assign pslverr_o = 1'b0; // RQ23 RQ11
	assign fast_req_n_o = state_reg.cpu.fast_n;
	assign normal_req_n_o = state_reg.cpu.normal_n;
	assign vector_o = state_reg.cpu.vector;
	assign autovector_o = state_reg.autovec;
	assign fast_raw_n_o = state_reg.fast_raw_n;
	assign normal_raw_n_o = state_reg.normal_raw_n;

endmodule

// >>> verilog/intc_pkg.sv
// Purpose: Constants and carriers for the priority interrupt controller
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Offsets are byte addresses

package intc_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_SOURCES = 40; // Request inputs
	localparam int NUM_LEVELS = 32; // Priority levels
	localparam int LEVEL_W = 5; // Select field width
	localparam int ADDR_W = 12; // Decoded address bits

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] CONTROL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] FORCE_HIGH_OFS = 12'h008;
	localparam logic [11:0] FORCE_LOW_OFS = 12'h00C;
	localparam logic [11:0] LEVEL_PEND_OFS = 12'h010;
	localparam logic [11:0] NORMAL_EN_OFS = 12'h014;
	localparam logic [11:0] NORMAL_PEND_OFS = 12'h018;
	localparam logic [11:0] FAST_EN_OFS = 12'h01C;
	localparam logic [11:0] FAST_PEND_OFS = 12'h020;
	localparam logic [11:0] PRIO_BASE_OFS = 12'h040; // 40 words

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_THRESH_LSB = 0; // Threshold 4:0
	localparam int CTL_ENABLE_BIT = 5; // Threshold enable
	localparam int CTL_CLASS_BIT = 6; // Mask class select
	localparam int CTL_SEPFAST_BIT = 7; // Separate fast vectors
	localparam int CTL_AUTOVEC_BIT = 8; // Autovector select

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int STS_VEC_LSB = 0; // Vector 6:0
	localparam int STS_NORMAL_BIT = 8; // Normal request, active low
	localparam int STS_FAST_BIT = 9; // Fast request, active low

	// ----------------------------------------
	// Reset values and vector encodings
	// ----------------------------------------
	localparam logic AUTOVEC_RESET = 1'b1;
	localparam logic [1:0] VEC_HI_NORMAL = 2'b01;
	localparam logic [1:0] VEC_HI_FAST = 2'b10;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic autovector_select;
		logic separate_fast_vectors;
		logic mask_class_select;
		logic threshold_enable;
		logic [4:0] threshold;
	} control_s;

	typedef struct packed {
		logic fast_n;
		logic normal_n;
		logic [6:0] vector;
	} cpu_req_s;

endpackage

// >>> verif/intc_properties.sv
// Purpose: Port checks for the interrupt controller
// Assumes: One clock domain, reset active low
// Notes: Bound to the top module below
`timescale 1ns/1ps
module intc_properties (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [39:0] source_req_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic fast_req_n_o,
	input wire logic normal_req_n_o,
	input wire logic [6:0] vector_o,
	input wire logic autovector_o,
	input wire logic fast_raw_n_o,
	input wire logic normal_raw_n_o
);
	// ----------------
	// Request checks
	// ----------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_normal_yields: assert property (!fast_req_n_o |-> normal_req_n_o)
		else $error("normal request beside fast");
	a_wake_same: assert property (fast_raw_n_o == fast_req_n_o
		&& normal_raw_n_o == normal_req_n_o) else $error("wake mismatch");
	a_auto_novec: assert property (autovector_o |-> vector_o == 7'h00)
		else $error("vector under autovector");
	a_vec_band: assert property (!autovector_o && !fast_req_n_o
		|-> vector_o[6:5] inside {2'h1, 2'h2}) else $error("vector band");
	a_normal_band: assert property (!autovector_o && fast_req_n_o
		&& !normal_req_n_o |-> vector_o[6:5] == 2'h1) else $error("band");
	// Quiet inputs leave the requests alone, since nothing detects edges
	a_quiet_hold: assert property ((!psel_i && $stable(source_req_i))[*3]
		|=> $stable({fast_req_n_o, normal_req_n_o, vector_o}))
		else $error("request moved");
	// ----------------
	// Bus checks
	// ----------------
	a_ready_next: assert property (clk_en_i && psel_i && !penable_i
		|=> pready_o) else $error("no ready");
	a_ready_pulse: assert property (pready_o && clk_en_i |=> !pready_o)
		else $error("ready held");
	a_no_error: assert property (!pslverr_o) else $error("bus error");
	a_data_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("stray read data");
	c_fast: cover property (!fast_req_n_o);
	c_normal: cover property (!normal_req_n_o);
	c_sep: cover property (vector_o[6:5] == 2'h2);
endmodule
bind priority_interrupt_controller intc_properties i_intc_properties (
	.clock_i, .rst_n_i, .clk_en_i, .source_req_i, .psel_i, .penable_i,
	.prdata_o, .pready_o, .pslverr_o, .fast_req_n_o, .normal_req_n_o,
	.vector_o, .autovector_o, .fast_raw_n_o, .normal_raw_n_o);

// >>> verif/source_model.sv
// Purpose: Peripheral request sources facing the controller
// Assumes: Bench raises and clears flags by one-cycle pulses
// Notes: Requests are held levels, never pulses
`timescale 1ns/1ps
module source_model (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [39:0] raise_i,
	input wire logic [39:0] clear_i,
	output logic [39:0] req_o
);
	// Flag stays up until the service routine clears it
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_o <= 40'h00_0000_0000;
		end else begin
			req_o <= (req_o | raise_i) & ~clear_i;
		end
	end
endmodule

// >>> verif/priority_interrupt_controller_test.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: APB answers with zero wait states
// Notes: Reads are scored from a queue by a monitor
`timescale 1ns/1ps
module priority_interrupt_controller_test;
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, fa;
	logic [31:0] pwdata = 32'h0000_0000, prdata, fb;
	logic [39:0] raise = 40'h00_0000_0000, clear = 40'h00_0000_0000, req;
	logic pready, pslverr, fast_n, normal_n, autovec;
	logic [6:0] vec;
	logic [31:0] exp_q[$];
	int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 32'h0000_8002, s, l;
	always #4 clk = ~clk;
	source_model i_source_model (.clock_i(clk), .rst_n_i(rst_n),
		.raise_i(raise), .clear_i(clear), .req_o(req));
	priority_interrupt_controller i_priority_interrupt_controller (
		.clock_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
		.source_req_i(req), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.fast_req_n_o(fast_n), .normal_req_n_o(normal_n), .vector_o(vec),
		.autovector_o(autovec), .fast_raw_n_o(), .normal_raw_n_o());
	// ----------------
	// Tasks
	// ----------------
	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task test_done;
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Request held until the ready edge, then released
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ready is sampled at the rising edge that completes the access
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task src(input logic [39:0] u, input logic [39:0] dn);
		@(posedge clk);
		raise <= u;
		clear <= dn;
		@(posedge clk);
		raise <= 40'h00_0000_0000;
		clear <= 40'h00_0000_0000;
		repeat (2) @(posedge clk);
	endtask
	// Settled requests: fast_n, normal_n, vector
	task outs(input logic [8:0] e);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("requests", {23'h00_0000, e}, {23'h00_0000, fast_n, normal_n, vec});
	endtask
	task quiet;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("idle", 32'h0000_0003, {30'h0000_0000, fast_n, normal_n});
	endtask
	// Monitor scores each read in its access cycle
	always @(negedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
			chk("prdata", exp_q.pop_front(), prdata);
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(12'h000, 32'h0000_0100);
		rd(12'h004, 32'h0000_0380);
		rd(12'h014, 32'h0000_0000);
		rd(12'h01C, 32'h0000_0000);
		rd(12'h0DC, 32'h0000_0000);
		// Random source and level, by pin or by force bit
		for (int i = 0; i < 8; i++) begin
			s = $unsigned($random(seed)) % 40;
			l = $unsigned($random(seed)) % 32;
			fa = (s < 32) ? 12'h00C : 12'h008;
			fb = 32'h0000_0001 << (s % 32);
			apb(1'b1, 12'h040 + 12'(s * 4), 32'(l));
			rd(12'h040 + 12'(s * 4), 32'(l));
			if (i[0]) apb(1'b1, fa, fb);
			else src(40'h00_0000_0001 << s, 40'h00_0000_0000);
			rd(12'h010, 32'h0000_0001 << l);
			if (i[0]) apb(1'b1, fa, 32'h0000_0000);
			else src(40'h00_0000_0000, 40'h00_0000_0001 << s);
			rd(12'h010, 32'h0000_0000);
		end
		// Source 3 at level 20, source 5 at level 9 (fast)
		apb(1'b1, 12'h04C, 32'h0000_0014);
		apb(1'b1, 12'h054, 32'h0000_0009);
		apb(1'b1, 12'h014, 32'hFFFF_FFFF);
		apb(1'b1, 12'h01C, 32'h0000_0200);
		apb(1'b1, 12'h000, 32'h0000_0080);
		src(40'h00_0000_0028, 40'h00_0000_0000);
		rd(12'h020, 32'h0000_0200);
		rd(12'h018, 32'h0010_0200);
		rd(12'h004, 32'h0000_0149);
		outs(9'h0C9);
		apb(1'b1, 12'h000, 32'h0000_0000);
		outs(9'h0A9);
		apb(1'b1, 12'h01C, 32'h0000_0000);
		outs(9'h134);
		rd(12'h004, 32'h0000_0234);
		// Threshold and mask class
		apb(1'b1, 12'h014, 32'h0000_0200);
		apb(1'b1, 12'h000, 32'h0000_0028);
		outs(9'h129);
		apb(1'b1, 12'h000, 32'h0000_0029);
		quiet();
		apb(1'b1, 12'h01C, 32'h0000_0200);
		outs(9'h0A9);
		apb(1'b1, 12'h000, 32'h0000_0069);
		quiet();
		// Read-only and unmapped places
		apb(1'b1, 12'h000, 32'h0000_0000);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		rd(12'h010, 32'h0010_0200);
		rd(12'h0FC, 32'h0000_0000);
		src(40'h00_0000_0000, 40'h00_0000_0028);
		rd(12'h010, 32'h0000_0000);
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule
